// File: rtl/tws_eeprom_slave.sv
// two-wire serial eeprom target with page buffer and timed programming
//
// Function
// RULE_01: data changes only while serial clock low
// RULE_02: data falling with clock high is start
// RULE_03: data rising with clock high is stop
// RULE_04: eight-bit words, device acks ninth clock
// RULE_05: idle at reset, after stop and programming; after programming STANDBY_O waits for SCL clocks
// RULE_06: controller recovers with nine clocks, then start
// RULE_07: address word five-bit fixed prefix must match
// RULE_08: chip select bit matches hardwired select input
// RULE_09: seventh address bit is word address msb
// RULE_10: eighth bit high reads, low writes
// RULE_11: ack on match, else no ack, idle
// RULE_12: write protect blocks every array change; WP_I is checked only as programming starts
// RULE_13: word address: page bit, high, low bytes
// RULE_14: byte write: address, two bytes, data, stop
// RULE_15: stop after write starts timed programming, deaf
// RULE_16: page write up to 256 bytes, each acked
// RULE_17: writes bump low byte only, wrap page
// RULE_18: polling acks only after programming completes
// RULE_19: address counter holds last access plus one
// RULE_20: read counter wraps from top to zero
// RULE_21: current read shifts byte at counter
// RULE_22: random read uses dummy write, repeated start
// RULE_23: controller ack advances read, nack ends
// RULE_24: fixed prefix is a design parameter
// RULE_25: start mid-transfer abandons it without programming
// RULE_26: protected writes still acked, nothing programmed
`timescale 1ns/100ps
module tws_eeprom_slave
	import tws_pkg::*;
#(
	parameter int         PROG_CYCLES_P = PROG_CYCLES,
	parameter logic [4:0] DEV_PREFIX    = DEV_PREFIX_DEF // RULE_24
) (
	// core clock, reset, enable
	input  wire logic CLK_I,
	input  wire logic RST_B_I,
	input  wire logic CE_I,
	// two-wire link
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	output logic      SDA_O,
	output logic      SDA_OE_O,
	// straps and protection
	input  wire logic CHIP_SEL_I,
	input  wire logic WP_I,
	// status
	output logic      BUSY_O,
	output logic      STANDBY_O
);

	localparam int TMR_W = $clog2(PROG_CYCLES_P + 1);

	function automatic logic [ADDR_W-1:0] page_inc(
		input logic [ADDR_W-1:0] a
	);
		return {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 8'h01};
	endfunction : page_inc

	function automatic logic [ADDR_W-1:0] lin_inc(
		input logic [ADDR_W-1:0] a
	);
		return a + 17'h00001;
	endfunction : lin_inc

	// array and page buffer
	logic [WORD_W-1:0]     mem [0:(1<<ADDR_W)-1];
	logic [WORD_W-1:0]     page_buf [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] dirty;

	// link domain
	logic                  link_rst;
	logic                  start_det;
	logic                  stop_det;
	logic                  start_clr;
	logic                  start_rst;
	logic                  stop_rst;
	tws_link_state_e       state;
	logic [3:0]            cnt;
	logic [WORD_W-1:0]     sh;
	logic [WORD_W-1:0]     word;
	logic                  ack_en;
	logic [PAGE_W:0]       wa_hi;
	logic [ADDR_W-1:0]     addr_ctr;
	logic [WORD_W-1:0]     rd_byte;
	logic                  have_data;
	logic [PAGE_W:0]       wr_page;
	logic [1:0]            csel_s;
	logic [1:0]            done_s;
	logic                  done_prev;
	logic                  dev_match;
	logic                  word_done;
	logic                  rd_slot;
	logic                  sda_oe;
	logic                  next_sda_oe;
	tws_link_stat_s        stat_l;

	// core domain
	tws_link_stat_s        stat_s1;
	tws_link_stat_s        stat_s2;
	logic                  stop_prev;
	logic                  stop_rise;
	logic [1:0]            wp_s;
	tws_core_state_e       cstate;
	logic [PAGE_W-1:0]     idx;
	logic [TMR_W-1:0]      tmr;
	logic                  done_tog;

	// link logic reset, taken from a core-domain flop
	always_ff @(posedge CLK_I) begin
		link_rst <= !RST_B_I;
	end

	// start/stop are edges of data while the clock is high
	assign start_rst = link_rst | start_clr;
	assign stop_rst  = link_rst | start_clr;

	always_ff @(negedge SDA_I or posedge start_rst) begin
		if (start_rst) begin
			start_det <= 1'b0;
		end else if (SCL_I) begin
			start_det <= 1'b1; // RULE_02
		end
	end

	// stop mark survives the first clock after a start so that a
	// committed write can be told apart from an abandoned one
	always_ff @(posedge SDA_I or posedge stop_rst) begin
		if (stop_rst) begin
			stop_det <= 1'b0;
		end else if (SCL_I) begin
			stop_det <= 1'b1; // RULE_03
		end
	end

	assign word = {sh[WORD_W-2:0], SDA_I};

	// address word decode; a pending program keeps the device deaf
	assign dev_match = (word[7:3] == DEV_PREFIX) && // RULE_07
		(word[2] == csel_s[1]) && // RULE_08
		!have_data; // RULE_15 RULE_18

	assign word_done = !start_det && !stop_det &&
		(state != L_IDLE) && (cnt == ACK_SLOT - 4'h1);
	assign rd_slot = !start_det && !stop_det &&
		(state == L_RDATA) && (cnt == ACK_SLOT);

	// pin straps and core handshake into the link domain
	always_ff @(posedge SCL_I or posedge link_rst) begin
		if (link_rst) begin
			csel_s    <= 2'h0;
			done_s    <= 2'h0;
			done_prev <= 1'b0;
		end else begin
			csel_s    <= {csel_s[0], CHIP_SEL_I};
			done_s    <= {done_s[0], done_tog};
			done_prev <= done_s[1];
		end
	end

	// frame sequencer
	always_ff @(posedge SCL_I or posedge link_rst) begin
		if (link_rst) begin
			state     <= L_IDLE; // RULE_05
			cnt       <= CNT_RST;
			sh        <= 8'h00;
			ack_en    <= 1'b0;
			start_clr <= 1'b0;
		end else begin
			start_clr <= start_det;
			if (start_det) begin
				state  <= L_DEV; // RULE_25
				cnt    <= 4'h1;
				sh     <= {7'h00, SDA_I};
				ack_en <= 1'b0;
			end else if (stop_det || state == L_IDLE) begin
				state  <= L_IDLE; // RULE_03
				cnt    <= CNT_RST;
				ack_en <= 1'b0;
			end else if (cnt != ACK_SLOT) begin
				sh  <= word; // RULE_04
				cnt <= cnt + 4'h1;
				if (word_done) begin
					unique case (state)
						L_DEV: begin
							if (dev_match) begin
								ack_en <= 1'b1; // RULE_11
								state  <= word[0] ? L_RDATA
									: L_ADDR_HI; // RULE_10
							end else begin
								state <= L_IDLE; // RULE_11
							end
						end
						L_ADDR_HI: begin
							ack_en <= 1'b1; // RULE_13
							state  <= L_ADDR_LO;
						end
						L_ADDR_LO: begin
							ack_en <= 1'b1; // RULE_13
							state  <= L_WDATA;
						end
						L_WDATA: begin
							ack_en <= 1'b1; // RULE_16 RULE_26
						end
						L_RDATA, L_IDLE: begin
							ack_en <= 1'b0;
						end
					endcase
				end
			end else begin
				cnt    <= CNT_RST;
				ack_en <= 1'b0;
				// controller nack ends the read
				if (state == L_RDATA && !ack_en && SDA_I) begin
					state <= L_IDLE; // RULE_21 RULE_23
				end
			end
		end
	end

	// word address, counter and read data
	always_ff @(posedge SCL_I or posedge link_rst) begin
		if (link_rst) begin
			wa_hi    <= 9'h000;
			addr_ctr <= ADDR_RST;
			rd_byte  <= 8'h00;
			wr_page  <= 9'h000;
		end else if (word_done) begin
			unique case (state)
				L_DEV: begin
					if (dev_match) begin
						wa_hi[PAGE_W] <= word[1]; // RULE_09
					end
				end
				L_ADDR_HI: begin
					wa_hi[PAGE_W-1:0] <= word; // RULE_13
				end
				L_ADDR_LO: begin
					addr_ctr <= {wa_hi, word}; // RULE_13 RULE_22
					wr_page  <= wa_hi;
				end
				L_WDATA: begin
					addr_ctr <= page_inc(addr_ctr); // RULE_17 RULE_19
				end
				L_RDATA, L_IDLE: begin
					rd_byte <= rd_byte;
				end
			endcase
		end else if (rd_slot && (ack_en || !SDA_I)) begin
			// array is only written while the link refuses access
			rd_byte  <= mem[addr_ctr]; // RULE_21 RULE_23
			addr_ctr <= lin_inc(addr_ctr); // RULE_19 RULE_20
		end
	end

	// page buffer; dirty marks the bytes to program
	always_ff @(posedge SCL_I or posedge link_rst) begin
		if (link_rst) begin
			dirty <= '0;
		end else if (word_done && state == L_ADDR_LO) begin
			dirty <= '0;
		end else if (word_done && state == L_WDATA) begin
			dirty[addr_ctr[PAGE_W-1:0]] <= 1'b1; // RULE_17
		end
	end

	always_ff @(posedge SCL_I) begin
		if (word_done && state == L_WDATA) begin
			page_buf[addr_ctr[PAGE_W-1:0]] <= word; // RULE_16 RULE_17
		end
	end

	// write pending flag, set by the first data byte, held until programming is done or a start abandons the write
	always_ff @(posedge SCL_I or posedge link_rst) begin
		if (link_rst) begin
			have_data <= 1'b0;
		end else if (word_done && state == L_WDATA) begin
			have_data <= 1'b1; // RULE_14 RULE_16
		end else if (start_det && !stop_det) begin
			have_data <= 1'b0; // RULE_25
		end else if (done_s[1] != done_prev) begin
			have_data <= 1'b0; // RULE_18
		end
	end

	// data line moves only on the falling clock
	assign next_sda_oe = !start_det && !stop_det &&
		((ack_en && cnt == ACK_SLOT) || // RULE_04
		(state == L_RDATA && !ack_en && cnt < ACK_SLOT &&
		!rd_byte[3'h7 - cnt[2:0]])); // RULE_21 RULE_23

	always_ff @(negedge SCL_I or posedge link_rst) begin
		if (link_rst) begin
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe; // RULE_01
		end
	end

	// open drain: only ever pulls low
	assign SDA_O    = 1'b0;
	assign SDA_OE_O = sda_oe;

	assign stat_l.stop      = stop_det;
	assign stat_l.have_data = have_data;
	assign stat_l.active    = (state != L_IDLE);

	// link status and protect pin into the core domain
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			stat_s1   <= '0;
			stat_s2   <= '0;
			stop_prev <= 1'b0;
			wp_s      <= 2'h0;
		end else if (CE_I) begin
			stat_s1   <= stat_l;
			stat_s2   <= stat_s1;
			stop_prev <= stat_s2.stop;
			wp_s      <= {wp_s[0], WP_I};
		end
	end

	assign stop_rise = stat_s2.stop && !stop_prev;

	// programming sequencer; timer spans copy and settle time
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			cstate   <= C_IDLE; // RULE_05
			idx      <= 8'h00;
			tmr      <= '0;
			done_tog <= 1'b0;
		end else if (CE_I) begin
			unique case (cstate)
				C_IDLE: begin
					if (stop_rise && stat_s2.have_data) begin
						if (wp_s[1]) begin
							done_tog <= !done_tog; // RULE_12 RULE_26
						end else begin
							cstate <= C_COPY; // RULE_15
							idx    <= 8'h00;
							tmr    <= '0;
						end
					end
				end
				C_COPY: begin
					idx <= idx + 8'h01;
					tmr <= tmr + 1'b1;
					if (idx == 8'hff) begin
						cstate <= C_WAIT;
					end
				end
				C_WAIT: begin
					tmr <= tmr + 1'b1;
					if (tmr >= TMR_W'(PROG_CYCLES_P - 1)) begin
						cstate   <= C_IDLE; // RULE_15
						done_tog <= !done_tog; // RULE_18
					end
				end
			endcase
		end
	end

	// array write port, one buffered byte per cycle
	always_ff @(posedge CLK_I) begin
		if (RST_B_I && CE_I && cstate == C_COPY && dirty[idx]) begin
			mem[{wr_page, idx}] <= page_buf[idx]; // RULE_12 RULE_17
		end
	end

	// status outputs
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I) begin
			BUSY_O    <= 1'b0;
			STANDBY_O <= 1'b1; // RULE_05
		end else if (CE_I) begin
			BUSY_O    <= (cstate != C_IDLE);
			STANDBY_O <= (cstate == C_IDLE) && !stat_s2.have_data &&
				(stat_s2.stop || !stat_s2.active); // RULE_05
		end
	end

endmodule : tws_eeprom_slave

// File: rtl/tws_pkg.sv
// shared constants and types for the two-wire eeprom target
package tws_pkg;

	// array geometry
	localparam int ADDR_W = 17;
	localparam int PAGE_W = 8;
	localparam int WORD_W = 8;
	localparam int PAGE_BYTES = 256;

	// bit position of the ack slot within a nine-clock word
	localparam logic [3:0] ACK_SLOT = 4'h8;

	// customary fixed prefix of the device address word
	localparam logic [4:0] DEV_PREFIX_DEF = 5'h14;

	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
	localparam logic [3:0] CNT_RST = 4'h0;

	// programming_cycle_time, longest figure, rounded down
	localparam int PROG_TIME_NS = 10000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		L_IDLE,
		L_DEV,
		L_ADDR_HI,
		L_ADDR_LO,
		L_WDATA,
		L_RDATA
	} tws_link_state_e;

	typedef enum logic [1:0] {
		C_IDLE,
		C_COPY,
		C_WAIT
	} tws_core_state_e;

	// link status carried into the core clock domain
	typedef struct packed {
		logic stop;
		logic have_data;
		logic active;
	} tws_link_stat_s;

endpackage : tws_pkg

// File: dv/tws_bfm.sv
// two-wire bus controller model driving the link clock and data
`timescale 1ns/100ps
module tws_bfm (
	// link
	output logic      scl_o,
	output logic      sda_low_o,
	input  wire logic sda_i
);
	// clock stands high between frames; released data floats to the pull-up
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	task start();
		#1.5 sda_low_o = 1'b0;
		#1.5 scl_o = 1'b1;
		#1.5 sda_low_o = 1'b1;
		#1.5 scl_o = 1'b0;
	endtask : start

	task stop();
		#1.5 sda_low_o = 1'b1;
		#1.5 scl_o = 1'b1;
		#1.5 sda_low_o = 1'b0;
		#1.5;
	endtask : stop

	// nine clocks, msb first; data moves only while the clock is low
	task xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#1.5 sda_low_o = !tx[i];
			#1.5 scl_o = 1'b1;
			rx[i] = sda_i;
			#3 scl_o = 1'b0;
		end
	endtask : xfer
endmodule : tws_bfm

// File: dv/tws_eeprom_slave_properties.sv
// concurrent checks on the two-wire eeprom target ports
`timescale 1ns/100ps
module tws_eeprom_slave_properties
	import tws_pkg::*;
#(
	parameter int PROG_CYCLES_P = PROG_CYCLES
) (
	// core
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CE_I,
	// link
	input wire logic SCL_I,
	input wire logic SDA_I,
	input wire logic SDA_O,
	input wire logic SDA_OE_O,
	// straps and status
	input wire logic CHIP_SEL_I,
	input wire logic WP_I,
	input wire logic BUSY_O,
	input wire logic STANDBY_O
);
	int busy_cnt;

	// frozen core cycles do not count toward the programming time
	always_ff @(posedge CLK_I) begin
		if (!RST_B_I || !BUSY_O)
			busy_cnt <= 0;
		else if (CE_I)
			busy_cnt <= busy_cnt + 1;
	end

	sequence busy_start;
		$rose(BUSY_O);
	endsequence
	sequence busy_hold;
		(BUSY_O && !STANDBY_O)[*8];
	endsequence

	drain_low_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		SDA_O == 1'b0) else $error("data output not low");
	// at a falling edge the sampled clock is still high
	data_on_low_a: assert property (@(edge SCL_I) disable iff (!RST_B_I)
		SCL_I |-> $stable(SDA_OE_O)) else $error("data moved, clock high");
	reset_quiet_a: assert property (@(posedge CLK_I)
		!RST_B_I ##1 !RST_B_I |-> !BUSY_O && STANDBY_O && !SDA_OE_O)
		else $error("not idle in reset");
	busy_idle_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		BUSY_O |-> !STANDBY_O) else $error("standby while busy");
	busy_deaf_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		BUSY_O |-> !SDA_OE_O) else $error("answer while busy");
	busy_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		busy_start |-> busy_hold) else $error("busy too short");
	busy_len_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		$fell(BUSY_O) |-> busy_cnt >= PROG_CYCLES_P - 3
		&& busy_cnt <= PROG_CYCLES_P + 3) else $error("busy length off");
	protect_a: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
		WP_I[*8] |-> !$rose(BUSY_O)) else $error("programmed while protected");
endmodule : tws_eeprom_slave_properties

bind tws_eeprom_slave tws_eeprom_slave_properties #(
	.PROG_CYCLES_P(PROG_CYCLES_P)
) tws_eeprom_slave_properties_i (
	.CLK_I(CLK_I),
	.RST_B_I(RST_B_I),
	.CE_I(CE_I),
	.SCL_I(SCL_I),
	.SDA_I(SDA_I),
	.SDA_O(SDA_O),
	.SDA_OE_O(SDA_OE_O),
	.CHIP_SEL_I(CHIP_SEL_I),
	.WP_I(WP_I),
	.BUSY_O(BUSY_O),
	.STANDBY_O(STANDBY_O)
);

// File: dv/tws_eeprom_slave_bench.sv
// self-checking bench for the two-wire eeprom target
`timescale 1ns/100ps
module tws_eeprom_slave_bench;
	import tws_pkg::*;
	localparam logic [7:0] WRW = {DEV_PREFIX_DEF, 3'b100};
	localparam logic [7:0] RDW = {DEV_PREFIX_DEF, 3'b101};
	logic       clk;
	logic       rst_b;
	logic       wp;
	logic       scl;
	logic       sda_low;
	logic       oe;
	logic       busy;
	logic       standby;
	logic       sda;
	logic [8:0] rx;
	int         error_cnt = 0;
	int         checked = 0;

	// open-drain wire with pull-up
	assign sda = !(sda_low || oe);

	tws_eeprom_slave #(.PROG_CYCLES_P(300)) tws_eeprom_slave_i (
		.CLK_I(clk),
		.RST_B_I(rst_b),
		.CE_I(1'b1),
		.SCL_I(scl),
		.SDA_I(sda),
		.SDA_O(),
		.SDA_OE_O(oe),
		.CHIP_SEL_I(1'b1),
		.WP_I(wp),
		.BUSY_O(busy),
		.STANDBY_O(standby)
	);
	tws_bfm tws_bfm_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task report_and_stop();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %0t: %s got %h exp %h", $time, s, got, exp);
		end
	endtask : chk

	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task dev(input logic [7:0] w, input logic ack);
		tws_bfm_i.start();
		tws_bfm_i.xfer({w, 1'b1}, rx);
		chk(8'(rx[0]), 8'(!ack), "address ack");
	endtask : dev

	task put(input logic [7:0] b);
		tws_bfm_i.xfer({b, 1'b1}, rx);
		chk(8'(rx[0]), 8'h00, "byte ack");
	endtask : put

	task rd(input logic [7:0] exp, input logic more);
		tws_bfm_i.xfer({8'hff, !more}, rx);
		chk(rx[8:1], exp, "read data");
	endtask : rd

	task hdr(input logic [16:0] a);
		dev({DEV_PREFIX_DEF, 1'b1, a[16], 1'b0}, 1'b1);
		put(a[15:8]);
		put(a[7:0]);
	endtask : hdr

	task rrd(input logic [16:0] a, input logic [7:0] exp, input logic more);
		hdr(a);
		dev(RDW, 1'b1);
		rd(exp, more);
	endtask : rrd

	task wr(input logic [16:0] a, input logic [15:0] d, input logic two);
		hdr(a);
		put(d[15:8]);
		if (two)
			put(d[7:0]);
		tws_bfm_i.stop();
	endtask : wr

	// polls until the programming cycle lets the address word through
	task settle(input logic first_nack);
		int n;
		for (n = 0; n < 100; n++) begin
			cyc(4);
			tws_bfm_i.start();
			tws_bfm_i.xfer({WRW, 1'b1}, rx);
			tws_bfm_i.stop();
			if (n == 0 && first_nack)
				chk(8'(rx[0]), 8'h01, "busy poll");
			if (rx[0] === 1'b0)
				break;
		end
		if (n == 100) begin
			chk(8'h00, 8'h01, "poll timeout");
			report_and_stop();
		end
		cyc(4);
	endtask : settle

	task t_refuse();
		dev({5'h15, 3'b100}, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		dev({DEV_PREFIX_DEF, 3'b000}, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		$display("refuse test done");
	endtask : t_refuse

	task t_write_read();
		wr(17'h12345, 16'ha55a, 1'b1);
		cyc(6);
		chk(8'({busy, standby}), 8'h02, "programming status");
		settle(1'b1);
		rrd(17'h12345, 8'ha5, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		dev(RDW, 1'b1);
		rd(8'h5a, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		chk(8'(standby), 8'h01, "standby after read");
		$display("write read test done");
	endtask : t_write_read

	task t_wrap();
		wr(17'h001ff, 16'h3cc3, 1'b1);
		settle(1'b0);
		rrd(17'h00100, 8'hc3, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		wr(17'h1ffff, 16'h1100, 1'b0);
		settle(1'b0);
		wr(17'h00000, 16'h2200, 1'b0);
		settle(1'b0);
		rrd(17'h1ffff, 8'h11, 1'b1);
		rd(8'h22, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		$display("wrap test done");
	endtask : t_wrap

	task t_protect();
		wp = 1'b1;
		cyc(8);
		wr(17'h12345, 16'h0000, 1'b0);
		cyc(20);
		chk(8'(busy), 8'h00, "protected busy");
		wp = 1'b0;
		cyc(8);
		hdr(17'h12345);
		put(8'h00);
		dev(WRW, 1'b1);
		tws_bfm_i.stop();
		cyc(20);
		chk(8'(busy), 8'h00, "aborted busy");
		rrd(17'h12345, 8'ha5, 1'b0);
		tws_bfm_i.stop();
		cyc(4);
		$display("protect test done");
	endtask : t_protect

	initial begin
		wp = 1'b0;
		rst_b = 1'b0;
		cyc(5);
		rst_b = 1'b1;
		cyc(3);
		chk(8'({busy, standby}), 8'h01, "standby after reset");
		t_refuse();
		t_write_read();
		t_wrap();
		t_protect();
		report_and_stop();
	end
endmodule : tws_eeprom_slave_bench
